/* File: pnr_pkg.sv */
// Purpose: shared constants for pin remap and change notify block
// Assumes: 32-bit apb, two 16-pin ports, 24 remappable pins
// Notes: offsets are byte addresses within the route page
package pnr_pkg;
	localparam int NPORT = 2;
	localparam int PW = 16;
	localparam int NPIN = 32;
	localparam int NRP = 24;
	localparam int NIN = 23;
	localparam int NOUTF = 20;
	localparam int ISW = 5;
	localparam int OSW = 4;
	localparam int NINREG = 6;
	localparam int NOUTREG = 3;
	// port registers: index in paddr[7:4], port in paddr[8]
	localparam logic [3:0] REG_DIR = 4'h0;
	localparam logic [3:0] REG_LAT = 4'h1;
	localparam logic [3:0] REG_ANSEL = 4'h2;
	localparam logic [3:0] REG_PU = 4'h3;
	localparam logic [3:0] REG_PD = 4'h4;
	localparam logic [3:0] REG_CNCTL = 4'h5;
	localparam logic [3:0] REG_ENA = 4'h6;
	localparam logic [3:0] REG_STAT = 4'h7;
	localparam logic [3:0] REG_ENB = 4'h8;
	localparam logic [3:0] REG_FLAG = 4'h9;
	localparam logic [3:0] REG_LEVEL = 4'ha;
	localparam logic [3:0] REG_LAST = 4'ha;
	localparam logic [3:0] ROUTE_PAGE = 4'h2;
	localparam logic [7:0] OFF_IN_ROUTE = 8'h00;
	localparam logic [7:0] OFF_OUT_ROUTE = 8'h20;
	localparam logic [7:0] OFF_ROUTE_CTRL = 8'h40;
	localparam logic [7:0] OFF_UNLOCK = 8'h50;
	localparam int CN_ON_BIT = 15;
	localparam int CN_STYLE_BIT = 11;
	localparam int LOCK_BIT = 0;
	localparam logic [15:0] DIR_RST = 16'hffff;
	localparam logic [15:0] ANSEL_RST = 16'hffff;
	localparam logic [15:0] CNCTL_MASK = 16'h8800;
	localparam logic [4:0] RP_MAX = 5'h18;
	localparam logic [3:0] OUTF_MAX = 4'h0 + 4'(NOUTF - 16);
	localparam logic [31:0] KEY_FIRST = 32'haa99_6655;
	localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;
	typedef enum logic [1:0] {
		PNR_OP_BASE, PNR_OP_CLR, PNR_OP_SET, PNR_OP_INV
	} pnr_op_t;
	typedef enum logic [1:0] {
		PNR_UL_IDLE, PNR_UL_KEY1, PNR_UL_OPEN
	} pnr_ulk_t;
endpackage

/* File: pnr_cn_port.sv */
// Purpose: change detection, status and sticky flags for one port
// Assumes: pin levels synchronous to pclk, analog pins already zeroed
// Notes: hardware set beats software clear on flags and status
`timescale 1ns/1ps
module pnr_cn_port import pnr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [PW-1:0] level,
	input wire logic cn_on,
	input wire logic style,
	input wire logic [PW-1:0] en_a,
	input wire logic [PW-1:0] en_b,
	input wire logic [PW-1:0] dir,
	input wire logic rd_level,
	input wire logic flags_wr,
	input wire logic [PW-1:0] flags_wdata,
	output logic [PW-1:0] status_r,
	output logic [PW-1:0] flags_r,
	output logic irq_r
);
	logic [PW-1:0] prev_r;
	logic [PW-1:0] last_read_r;
	logic [PW-1:0] rise;
	logic [PW-1:0] fall;
	logic [PW-1:0] event_hit;

	assign rise = level & ~prev_r;
	assign fall = ~level & prev_r;
	always_comb begin
		if (!cn_on) begin
			event_hit = '0;
		end else if (style) begin
			// b/a pair: 01 rise, 10 fall, 11 both
			event_hit = (en_a & ~en_b & rise) | (en_b & ~en_a & fall) |
				(en_a & en_b & (rise | fall));
		end else begin
			event_hit = en_a & (level ^ last_read_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_read_r <= '0;
		end else if (rd_level) begin
			last_read_r <= level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
		end else begin
			status_r <= (rd_level ? '0 : status_r) |
				(cn_on ? (level ^ prev_r) : '0);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_wr ? flags_wdata : flags_r) | event_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= cn_on & |(flags_r & dir);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	flag_sticky_a: assert property (flags_r[0] && !flags_wr |=> flags_r[0])
		else $error("change flag dropped without clear");
	rise_only_a: assert property (cn_on && style && en_a[0] &&
		!en_b[0] && !level[0] && prev_r[0] && !flags_wr && !flags_r[0] |=>
		!flags_r[0])
		else $error("falling edge flagged in rise-only mode");
	mismatch_a: assert property (cn_on && !style && en_a[0] &&
		(level[0] != last_read_r[0]) |=> flags_r[0])
		else $error("mismatch not flagged");
	status_read_a: assert property (rd_level &&
		(level[0] == prev_r[0]) |=> !status_r[0])
		else $error("status not cleared by read");
	irq_input_a: assert property ((flags_r & dir) == '0 |=> !irq_r)
		else $error("output pins raised change interrupt");
endmodule

/* File: pnr_route_mux.sv */
// Purpose: decode input and output routing codes onto pins
// Assumes: remap pin n sits on pin index n-1
// Notes: purely combinational, the top registers every result
`timescale 1ns/1ps
module pnr_route_mux import pnr_pkg::*; (
	input wire logic [NPIN-1:0] pin_level,
	input wire logic [NIN*ISW-1:0] in_sel_flat,
	input wire logic [NRP*OSW-1:0] out_sel_flat,
	input wire logic [NOUTF-1:0] periph_out,
	output logic [NIN-1:0] periph_in_nxt,
	output logic [NPIN-1:0] rp_drive,
	output logic [NPIN-1:0] rp_active
);
	function automatic logic in_ok(input logic [ISW-1:0] s);
		return (s != 5'h00) && (s <= RP_MAX);
	endfunction

	function automatic logic out_ok(input logic [OSW-1:0] s);
		return s != 4'h0;
	endfunction

	genvar i;
	generate
		for (i = 0; i < NIN; i++) begin : g_in
			logic [ISW-1:0] s;
			assign s = in_sel_flat[i*ISW +: ISW];
			// unassigned and reserved codes read inactive low
			assign periph_in_nxt[i] = in_ok(s) ?
				pin_level[5'(s - 5'h01)] : 1'b0;
		end
		for (i = 0; i < NPIN; i++) begin : g_out
			if (i < NRP) begin : g_rp
				logic [OSW-1:0] s;
				logic [4:0] code;
				assign s = out_sel_flat[i*OSW +: OSW];
				assign code = {1'b0, s};
				assign rp_active[i] = out_ok(s);
				assign rp_drive[i] = out_ok(s) ?
					periph_out[5'(code - 5'h01)] : 1'b0;
			end else begin : g_fixed
				assign rp_active[i] = 1'b0;
				assign rp_drive[i] = 1'b0;
			end
		end
	endgenerate
endmodule

/* File: pnr_top.sv */
// Purpose: apb register file, pin drive and routing for port pins
// Assumes: pins and peripheral outputs synchronous to pclk
// Notes: one access cycle per transfer, pready never waits
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module pnr_top import pnr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0] pin_out,
	output logic [NPIN-1:0] pin_oe,
	output logic [NPIN-1:0] pin_pullup,
	output logic [NPIN-1:0] pin_pulldown,
	input wire logic [NOUTF-1:0] periph_out,
	output logic [NIN-1:0] periph_in,
	output logic [NPORT-1:0] cn_irq
);
	logic [PW-1:0] dir_r [NPORT];
	logic [PW-1:0] lat_r [NPORT];
	logic [PW-1:0] ansel_r [NPORT];
	logic [PW-1:0] pu_r [NPORT];
	logic [PW-1:0] pd_r [NPORT];
	logic [PW-1:0] cnctl_r [NPORT];
	logic [PW-1:0] ena_r [NPORT];
	logic [PW-1:0] enb_r [NPORT];
	logic [PW-1:0] cn_status [NPORT];
	logic [PW-1:0] cn_flags [NPORT];
	logic [ISW-1:0] in_sel_r [NIN];
	logic [OSW-1:0] out_sel_r [NRP];
	logic lock_r;
	pnr_ulk_t ul_state_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [NPIN-1:0] pin_out_r, pin_oe_r, pin_pullup_r, pin_pulldown_r;
	logic [NIN-1:0] periph_in_r;
	logic [NPIN-1:0] pin_level, dir_all, lat_all, ansel_all, pu_all, pd_all;
	logic [NIN*ISW-1:0] in_sel_flat;
	logic [NRP*OSW-1:0] out_sel_flat;
	logic [NIN-1:0] periph_in_nxt;
	logic [NPIN-1:0] rp_drive, rp_active;
	logic [31:0] rdata_nxt;
	logic hit_nxt;
	logic xfer, wr;
	logic port_hit, route_pg;
	logic pi;
	logic [3:0] ridx;
	pnr_op_t op;
	logic [7:0] roff;

	function automatic logic [PW-1:0] alias_apply(input logic [PW-1:0] old,
		input logic [PW-1:0] w, input pnr_op_t o);
		unique case (o)
			PNR_OP_BASE: return w;
			PNR_OP_CLR: return old & ~w;
			PNR_OP_SET: return old | w;
			PNR_OP_INV: return old ^ w;
		endcase
	endfunction

	assign xfer = psel & penable & pready_r;
	assign wr = xfer & pwrite;
	assign pi = paddr[8];
	assign ridx = paddr[7:4];
	assign op = pnr_op_t'(paddr[3:2]);
	assign roff = paddr[7:0];
	assign port_hit = (paddr[11:9] == 3'h0) && (ridx <= REG_LAST);
	assign route_pg = (paddr[11:8] == ROUTE_PAGE);

	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			assign dir_all[g*PW +: PW] = dir_r[g];
			assign lat_all[g*PW +: PW] = lat_r[g];
			assign ansel_all[g*PW +: PW] = ansel_r[g];
			assign pu_all[g*PW +: PW] = pu_r[g];
			assign pd_all[g*PW +: PW] = pd_r[g];
			pnr_cn_port u_cn (
				.pclk(pclk),
				.presetn(presetn),
				.level(pin_level[g*PW +: PW]),
				.cn_on(cnctl_r[g][CN_ON_BIT]),
				.style(cnctl_r[g][CN_STYLE_BIT]),
				.en_a(ena_r[g]),
				.en_b(enb_r[g]),
				.dir(dir_r[g]),
				.rd_level(xfer && !pwrite && port_hit && pi == 1'(g) &&
					ridx == REG_LEVEL && op == PNR_OP_BASE),
				.flags_wr(wr && port_hit && pi == 1'(g) && ridx == REG_FLAG),
				.flags_wdata(alias_apply(cn_flags[g], pwdata[PW-1:0], op)),
				.status_r(cn_status[g]),
				.flags_r(cn_flags[g]),
				.irq_r(cn_irq[g])
			);
		end
		for (g = 0; g < NIN; g++) begin : g_inf
			assign in_sel_flat[g*ISW +: ISW] = in_sel_r[g];
		end
		for (g = 0; g < NRP; g++) begin : g_outf
			assign out_sel_flat[g*OSW +: OSW] = out_sel_r[g];
		end
	endgenerate

	// analog pins read low
	assign pin_level = pin_in & ~ansel_all;

	pnr_route_mux u_mux (
		.pin_level(pin_level),
		.in_sel_flat(in_sel_flat),
		.out_sel_flat(out_sel_flat),
		.periph_out(periph_out),
		.periph_in_nxt(periph_in_nxt),
		.rp_drive(rp_drive),
		.rp_active(rp_active)
	);

	// read data captured in setup phase
	always_comb begin
		rdata_nxt = '0;
		hit_nxt = 1'b0;
		if (port_hit) begin
			hit_nxt = 1'b1;
			if (op == PNR_OP_BASE) begin
				unique case (ridx)
					REG_DIR: rdata_nxt[PW-1:0] = dir_r[pi];
					REG_LAT: rdata_nxt[PW-1:0] = lat_r[pi];
					REG_ANSEL: rdata_nxt[PW-1:0] = ansel_r[pi];
					REG_PU: rdata_nxt[PW-1:0] = pu_r[pi];
					REG_PD: rdata_nxt[PW-1:0] = pd_r[pi];
					REG_CNCTL: rdata_nxt[PW-1:0] = cnctl_r[pi];
					REG_ENA: rdata_nxt[PW-1:0] = ena_r[pi];
					REG_STAT: rdata_nxt[PW-1:0] = cn_status[pi];
					REG_ENB: rdata_nxt[PW-1:0] = enb_r[pi];
					REG_FLAG: rdata_nxt[PW-1:0] = cn_flags[pi];
					default: rdata_nxt[PW-1:0] = pin_level[pi*PW +: PW];
				endcase
			end
		end else if (route_pg) begin
			for (int i = 0; i < NIN; i++) begin
				if (roff[7:5] == 3'h0 && roff[4:2] == 3'(i / 4)) begin
					hit_nxt = 1'b1;
					rdata_nxt[8*(i%4) +: ISW] = in_sel_r[i];
				end
			end
			for (int i = 0; i < NRP; i++) begin
				if (roff[7:5] == OFF_OUT_ROUTE[7:5] && roff[4:2] == 3'(i / 8)) begin
					hit_nxt = 1'b1;
					rdata_nxt[OSW*(i%8) +: OSW] = out_sel_r[i];
				end
			end
			if (roff == OFF_ROUTE_CTRL) begin
				hit_nxt = 1'b1;
				rdata_nxt[LOCK_BIT] = lock_r;
			end
			if (roff == OFF_UNLOCK) begin
				hit_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel & ~penable;
			if (psel && !penable) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
				pslverr_r <= ~hit_nxt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NPORT; p++) begin
				dir_r[p] <= DIR_RST;
				lat_r[p] <= '0;
				ansel_r[p] <= ANSEL_RST;
				pu_r[p] <= '0;
				pd_r[p] <= '0;
				cnctl_r[p] <= '0;
				ena_r[p] <= '0;
				enb_r[p] <= '0;
			end
		end else if (wr && port_hit) begin
			unique case (ridx)
				REG_DIR: dir_r[pi] <= alias_apply(dir_r[pi], pwdata[PW-1:0], op);
				REG_LAT: lat_r[pi] <= alias_apply(lat_r[pi], pwdata[PW-1:0], op);
				REG_ANSEL: ansel_r[pi] <= alias_apply(ansel_r[pi],
					pwdata[PW-1:0], op);
				REG_PU: pu_r[pi] <= alias_apply(pu_r[pi], pwdata[PW-1:0], op);
				REG_PD: pd_r[pi] <= alias_apply(pd_r[pi], pwdata[PW-1:0], op);
				REG_CNCTL: cnctl_r[pi] <= CNCTL_MASK &
					alias_apply(cnctl_r[pi], pwdata[PW-1:0], op);
				REG_ENA: ena_r[pi] <= alias_apply(ena_r[pi], pwdata[PW-1:0], op);
				REG_ENB: enb_r[pi] <= alias_apply(enb_r[pi], pwdata[PW-1:0], op);
				default: ;
			endcase
		end
	end

	// separate input and output route sets, both behind the lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NIN; i++) in_sel_r[i] <= '0;
			for (int i = 0; i < NRP; i++) out_sel_r[i] <= '0;
		end else if (wr && route_pg && !lock_r) begin
			for (int i = 0; i < NIN; i++) begin
				if (roff[7:5] == 3'h0 && roff[4:2] == 3'(i / 4))
					in_sel_r[i] <= pwdata[8*(i%4) +: ISW];
			end
			for (int i = 0; i < NRP; i++) begin
				if (roff[7:5] == OFF_OUT_ROUTE[7:5] && roff[4:2] == 3'(i / 8))
					out_sel_r[i] <= pwdata[OSW*(i%8) +: OSW];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ul_state_r <= PNR_UL_IDLE;
			lock_r <= 1'b0;
		end else if (wr && route_pg && roff == OFF_UNLOCK) begin
			if (pwdata == KEY_FIRST)
				ul_state_r <= PNR_UL_KEY1;
			else if (ul_state_r == PNR_UL_KEY1 && pwdata == KEY_SECOND)
				ul_state_r <= PNR_UL_OPEN;
			else
				ul_state_r <= PNR_UL_IDLE;
		end else if (wr && route_pg && roff == OFF_ROUTE_CTRL) begin
			if (ul_state_r == PNR_UL_OPEN)
				lock_r <= pwdata[LOCK_BIT];
			ul_state_r <= PNR_UL_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_r <= '0;
			pin_oe_r <= '0;
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				if (rp_active[i] && !ansel_all[i]) begin
					pin_out_r[i] <= rp_drive[i];
					pin_oe_r[i] <= 1'b1;
				end else begin
					pin_out_r[i] <= lat_all[i];
					pin_oe_r[i] <= ~dir_all[i];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_pullup_r <= '0;
			pin_pulldown_r <= '0;
			periph_in_r <= '0;
		end else begin
			pin_pullup_r <= pu_all;
			pin_pulldown_r <= pd_all;
			periph_in_r <= periph_in_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pin_out = pin_out_r;
	assign pin_oe = pin_oe_r;
	assign pin_pullup = pin_pullup_r;
	assign pin_pulldown = pin_pulldown_r;
	assign periph_in = periph_in_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lock_discard_a: assert property (wr && route_pg && lock_r |=>
		$stable(in_sel_flat) && $stable(out_sel_flat))
		else $error("route written while locked");
	lock_guard_a: assert property ($changed(lock_r) |->
		$past(ul_state_r) == PNR_UL_OPEN)
		else $error("lock changed without unlock");
	analog_first_a: assert property (ansel_all[0] && dir_all[0] |=>
		!pin_oe_r[0])
		else $error("remap overrode analog pin");
	remap_wins_a: assert property (rp_active[0] && !ansel_all[0] |=>
		pin_oe_r[0] && pin_out_r[0] == $past(rp_drive[0]))
		else $error("remap did not drive pin");
	null_out_a: assert property (out_sel_r[0] == 4'h0 |=>
		pin_oe_r[0] == !$past(dir_all[0]) && pin_out_r[0] == $past(lat_all[0]))
		else $error("null route drove pin");
	reserved_in_a: assert property (in_sel_r[0] > RP_MAX |=>
		!periph_in_r[0])
		else $error("reserved code reached pin");
	route_in_a: assert property (in_sel_r[0] == 5'h03 |=>
		periph_in_r[0] == $past(pin_level[2]))
		else $error("input route wrong pin");
	alias_clr_a: assert property (wr && port_hit && !pi && ridx == REG_DIR &&
		op == PNR_OP_CLR |=> dir_r[0] == ($past(dir_r[0]) & ~$past(pwdata[15:0])))
		else $error("clear alias wrong");
endmodule

/* File: pnr_pin_model.sv */
// Purpose: far-side pins and peripheral outputs for the remap bench
// Assumes: block outputs settle before the next rising edge
// Notes: undriven, unpulled pins toggle so stale levels never pass
`timescale 1ns/1ps
module pnr_pin_model import pnr_pkg::*; (
	input wire logic pclk,
	input wire logic [NPIN-1:0] ext_level,
	input wire logic [NPIN-1:0] ext_drive,
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pullup,
	input wire logic [NPIN-1:0] pin_pulldown,
	input wire logic [NOUTF-1:0] periph_val,
	output logic [NPIN-1:0] pin_in,
	output logic [NOUTF-1:0] periph_out
);
	initial begin
		pin_in = '0;
		periph_out = '0;
	end
	always @(posedge pclk) begin
		periph_out <= periph_val;
		for (int i = 0; i < NPIN; i++) begin
			if (pin_oe[i])
				pin_in[i] <= pin_out[i];
			else if (ext_drive[i])
				pin_in[i] <= ext_level[i];
			else if (pin_pullup[i] | pin_pulldown[i])
				pin_in[i] <= pin_pullup[i];
			else
				pin_in[i] <= ~pin_in[i];
		end
	end
endmodule

/* File: pin_remap_and_change_notify_test.sv */
// Purpose: self-checking bench for the pin remap and change block
// Assumes: slave may hold off pready; master waits for it
// Notes: read results are queued by the driver, checked by a monitor
`timescale 1ns/1ps
module pin_remap_and_change_notify_test import pnr_pkg::*;;
	typedef struct {
		string nm;
		logic [31:0] e;
		logic [31:0] m;
		logic err;
	} pnr_note_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr;
	logic [NPIN-1:0] ext_level = '0, ext_drive = 32'h00ff_ffff;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown;
	logic [NOUTF-1:0] periph_val = '0, periph_out;
	logic [NIN-1:0] periph_in;
	logic [NPORT-1:0] cn_irq;
	int mismatches = 0;
	int check_count = 0;
	int seed = 32'h178a;
	pnr_note_t notes[$];
	pnr_note_t mon;

	always #2.5 pclk = ~pclk;

	pnr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.pin_pulldown(pin_pulldown), .periph_out(periph_out),
		.periph_in(periph_in), .cn_irq(cn_irq));

	pnr_pin_model u_far (.pclk(pclk), .ext_level(ext_level),
		.ext_drive(ext_drive), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
		.periph_val(periph_val), .pin_in(pin_in),
		.periph_out(periph_out));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input string nm, input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffff_ffff, input logic err = 1'b0);
		pnr_note_t n;
		n = '{nm, e, m, err};
		notes.push_back(n);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task settle;
		repeat (4) @(posedge pclk);
	endtask

	task unlock;
		wr(12'h250, KEY_FIRST);
		wr(12'h250, KEY_SECOND);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (notes.size() == 0) begin
				chk("unexpected read", 32'h0, 32'h1);
			end else begin
				mon = notes.pop_front();
				chk(mon.nm, mon.e & mon.m, prdata & mon.m);
				chk("pslverr", 32'(mon.err), 32'(pslverr));
			end
		end
	end

	initial begin
		#200000;
		mismatches++;
		stop_test;
	end

	initial begin
		logic [4:0] c;
		logic [4:0] codes [7];
		logic e;
		codes = '{5'h01, 5'h18, 5'h19, 5'h1f, 5'h00, 5'h03, 5'h0c};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("idle outputs", 32'h0, 32'({periph_in, pin_oe[0]}));
		rd("direction", 12'h000, 32'h0000_ffff);
		rd("out route", 12'h220, 32'h0);
		rd("unmapped", 12'h300, 32'h0, 32'h0, 1'b1);
		wr(12'h020, 32'h0);
		wr(12'h120, 32'h0);
		wr(12'h030, 32'h0000_a5a5);
		wr(12'h140, 32'h0000_5a5a);
		settle;
		chk("pullup", 32'h0000_a5a5, pin_pullup);
		chk("pulldown", 32'h5a5a_0000, pin_pulldown);
		wr(12'h004, 32'h0000_0f00);
		rd("dir clear", 12'h000, 32'h0000_f0ff);
		wr(12'h00c, 32'h0000_ff00);
		rd("dir invert", 12'h000, 32'h0000_0fff);
		wr(12'h008, 32'h0000_f000);
		rd("dir set", 12'h000, 32'h0000_ffff);
		rd("alias read", 12'h008, 32'h0);
		wr(12'h050, 32'h0000_8800);
		wr(12'h060, 32'h0000_000b);
		wr(12'h080, 32'h0000_000c);
		wr(12'h090, 32'h0);
		ext_level[3:0] <= 4'hf;
		settle;
		rd("rise flags", 12'h090, 32'h0000_000b, 32'hf);
		chk("irq set", 32'h1, 32'(cn_irq));
		wr(12'h090, 32'h0);
		settle;
		chk("irq cleared", 32'h0, 32'(cn_irq[0]));
		ext_level[3:0] <= 4'h0;
		settle;
		rd("fall flags", 12'h090, 32'h0000_000c, 32'hf);
		rd("status", 12'h070, 32'h0000_000f, 32'hf);
		rd("level", 12'h0a0, 32'h0, 32'hf);
		rd("status read", 12'h070, 32'h0, 32'hf);
		wr(12'h050, 32'h0000_8000);
		wr(12'h090, 32'h0);
		ext_level[1:0] <= 2'h3;
		settle;
		rd("mismatch", 12'h090, 32'h0000_0003, 32'hf);
		wr(12'h050, 32'h0);
		settle;
		chk("port off", 32'h0, 32'(cn_irq[0]));
		wr(12'h050, 32'h0000_8000);
		settle;
		chk("port on", 32'h1, 32'(cn_irq[0]));
		wr(12'h004, 32'h0000_0003);
		settle;
		chk("output pin", 32'h0, 32'(cn_irq[0]));
		wr(12'h008, 32'h0000_0003);
		wr(12'h050, 32'h0);
		for (int i = 0; i < 7; i++) begin
			ext_level <= $random(seed);
			c = codes[i];
			wr(12'h200, 32'(c));
			wr(12'h214, {11'h0, c, 16'h0});
			settle;
			e = (c >= 5'h01 && c <= RP_MAX) ? ext_level[c - 5'h01] : 1'b0;
			chk("input route", 32'({e, e}),
				32'({periph_in[22], periph_in[0]}));
		end
		wr(12'h010, 32'h0000_0001);
		wr(12'h004, 32'h0000_0001);
		wr(12'h220, 32'h0000_0001);
		wr(12'h228, 32'hf000_0000);
		for (int i = 0; i < 3; i++) begin
			periph_val <= NOUTF'($random(seed));
			settle;
			chk("remap drive", 32'({periph_val[14], periph_val[0]}),
				32'({pin_out[23], pin_out[0]}));
			chk("remap oe", 32'h3, 32'({pin_oe[23], pin_oe[0]}));
		end
		wr(12'h220, 32'h0);
		settle;
		chk("latch drive", 32'h3, 32'({pin_oe[0], pin_out[0]}));
		wr(12'h008, 32'h0000_0001);
		wr(12'h220, 32'h0000_0001);
		wr(12'h028, 32'h0000_0001);
		settle;
		chk("analog pin", 32'h0, 32'(pin_oe[0]));
		wr(12'h024, 32'h0000_0001);
		wr(12'h240, 32'h1);
		wr(12'h220, 32'h2);
		rd("keyless lock", 12'h240, 32'h0);
		unlock;
		wr(12'h240, 32'h1);
		rd("lock", 12'h240, 32'h1);
		wr(12'h220, 32'h3);
		wr(12'h200, 32'h5);
		rd("locked out", 12'h220, 32'h2);
		rd("locked in", 12'h200, 32'h0000_000c);
		wr(12'h240, 32'h0);
		rd("keyless unlock", 12'h240, 32'h1);
		unlock;
		wr(12'h240, 32'h0);
		wr(12'h220, 32'h3);
		rd("unlocked", 12'h220, 32'h3);
		stop_test;
	end
endmodule
